// file: core/stepper_regs_pkg.sv
// constants for the stepper diagnostic and control register bank
// assumes 8-bit registers reached through a byte-wide register port
package stepper_regs_pkg;

  // register port geometry
  localparam int ADDR_W = 6;
  localparam int DATA_W = 8;

  // register addresses
  localparam logic [5:0] ADDR_OC_DIAG     = 6'h01;
  localparam logic [5:0] ADDR_THERMAL     = 6'h02;
  localparam logic [5:0] ADDR_TORQUE_SLEW = 6'h03;
  localparam logic [5:0] ADDR_OUT_DECAY   = 6'h04;
  localparam logic [5:0] ADDR_CTRL_3      = 6'h05;
  localparam logic [5:0] ADDR_CTRL_4      = 6'h06;
  localparam logic [5:0] ADDR_CTRL_5      = 6'h07;
  localparam logic [5:0] ADDR_CTRL_6      = 6'h08;
  localparam logic [5:0] ADDR_CTRL_7      = 6'h09;

  // field positions
  localparam int TORQUE_LSB  = 4;
  localparam int SLEW_LSB    = 0;
  localparam int OUT_DIS_BIT = 7;
  localparam int OFF_LSB     = 3;
  localparam int DECAY_LSB   = 0;
  localparam int CLR_BIT     = 7;
  localparam int LOCK_LSB    = 4;
  localparam int RSVD_DIAG   = 2;

  // reset values (output-disable bit added per variant)
  localparam logic [7:0] TORQUE_SLEW_RST = 8'h00;
  localparam logic [7:0] OUT_DECAY_RST   = 8'h0F;
  localparam logic [7:0] CTRL_3_RST      = 8'h00;
  localparam logic [3:0] CTRL_4_LOW_RST  = 4'h0;
  localparam logic [2:0] LOCK_RST        = 3'h3;
  localparam logic [7:0] CTRL_5_RST      = 8'h08;
  localparam logic [7:0] CTRL_6_RST      = 8'h00;
  localparam logic [7:0] CTRL_7_RST      = 8'h00;

  // lock field codes
  localparam logic [2:0] LOCK_ON  = 3'h6;
  localparam logic [2:0] LOCK_OFF = 3'h3;

  // pwm off times in microseconds and their cycle counts
  localparam int CLK_MHZ    = 125;
  localparam int OFF_US_0   = 7;
  localparam int OFF_US_1   = 16;
  localparam int OFF_US_2   = 24;
  localparam int OFF_US_3   = 32;
  localparam logic [11:0] OFF_CYC_0 = 12'(OFF_US_0 * CLK_MHZ);
  localparam logic [11:0] OFF_CYC_1 = 12'(OFF_US_1 * CLK_MHZ);
  localparam logic [11:0] OFF_CYC_2 = 12'(OFF_US_2 * CLK_MHZ);
  localparam logic [11:0] OFF_CYC_3 = 12'(OFF_US_3 * CLK_MHZ);

endpackage

// file: core/stepper_diag_and_ctrl_regs.sv
// diagnostic status and control register bank of a stepper driver
// assumes register port strobes and detector inputs synchronous to clk
//
// Summary of operation
// (RULE_01) overcurrent diag at 0x01, read-only, resets zero
// (RULE_02) bits 7..4: second bridge FET overcurrent
// (RULE_03) bits 3..0: first bridge FET overcurrent
// (RULE_04) 0x02: temperature warnings, shutdown in bits 7..5
// (RULE_05) bit 4 set on stall learning success
// (RULE_06) bit 3 stall flag, bit 2 reads zero
// (RULE_07) bits 1,0: open load second, first bridge
// (RULE_08) 0x03..0x09 read/write, other addresses untouched
// (RULE_09) torque scale in 0x03 bits 7:4
// (RULE_10) slew rate in 0x03 bits 1:0
// (RULE_11) 0x04 bit 7 disables outputs, variant reset
// (RULE_12) effective disable ORs bit with pin
// (RULE_13) host clears open-load enable before disabling
// (RULE_14) pwm off time select, reset 01b
// (RULE_15) decay codes 000..101 fixed decay modes
// (RULE_16) adaptive decay codes, decay resets 111b
// (RULE_17) lock code blocks writes, unlock code releases
// (RULE_18) fault clear empties latched flags, self-clears
// (RULE_19) flags set from external detector inputs
`timescale 1ns/1ps

module stepper_diag_and_ctrl_regs #(
  parameter int         ADDR_W        = stepper_regs_pkg::ADDR_W,
  parameter int         DATA_W        = stepper_regs_pkg::DATA_W,
  parameter logic [0:0] OUT_DIS_RESET = 1'h0
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // register port
  input  wire logic              reg_wr_en,
  input  wire logic              reg_rd_en,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  output logic      [DATA_W-1:0] reg_rdata,
  output logic                   reg_rd_valid,
  // overcurrent detectors
  input  wire logic              oc_b_half2_low,
  input  wire logic              oc_b_half2_high,
  input  wire logic              oc_b_half1_low,
  input  wire logic              oc_b_half1_high,
  input  wire logic              oc_a_half2_low,
  input  wire logic              oc_a_half2_high,
  input  wire logic              oc_a_half1_low,
  input  wire logic              oc_a_half1_high,
  // thermal, stall and open-load detectors
  input  wire logic              under_temp_warning,
  input  wire logic              over_temp_warning,
  input  wire logic              over_temp_shutdown,
  input  wire logic              stall_learning_done,
  input  wire logic              stall_detect,
  input  wire logic              open_load_second_bridge,
  input  wire logic              open_load_first_bridge,
  // external output-off pin
  input  wire logic              driver_off_pin,
  // control outputs
  output logic [3:0]             torque_scale,
  output logic [1:0]             slew_rate,
  output logic                   output_disable,
  output logic [1:0]             pwm_off_time,
  output logic [11:0]            pwm_off_cycles,
  output logic [2:0]             decay_mode,
  output logic                   open_load_detect_enable,
  output logic                   fault_clear,
  output logic                   regs_locked
);

  // flag latch: a new detection wins over a clear
  function automatic logic [7:0] latch_flags(input logic [7:0] cur,
                                             input logic [7:0] det,
                                             input logic       clr);
    latch_flags = (clr ? 8'h00 : cur) | det;
  endfunction

  // off-time code to cycle count
  function automatic logic [11:0] off_cycles(input logic [1:0] code);
    off_cycles = (code == 2'h0) ? stepper_regs_pkg::OFF_CYC_0 :
                 (code == 2'h1) ? stepper_regs_pkg::OFF_CYC_1 :
                 (code == 2'h2) ? stepper_regs_pkg::OFF_CYC_2 :
                                  stepper_regs_pkg::OFF_CYC_3;
  endfunction

  logic [7:0]  oc_diag_reg;
  logic [7:0]  thermal_reg;
  logic [7:0]  torque_slew_reg;
  logic [7:0]  out_decay_reg;
  logic [7:0]  ctrl_3_reg;
  logic [3:0]  ctrl_4_low_reg;
  logic [2:0]  lock_reg;
  logic [7:0]  ctrl_5_reg;
  logic [7:0]  ctrl_6_reg;
  logic [7:0]  ctrl_7_reg;
  logic        out_dis_reg;
  logic [11:0] off_cyc_reg;
  logic        fault_clear_reg;
  logic [7:0]  rdata_reg;
  logic        rd_valid_reg;
  logic        locked_reg;

  // address decode
  wire logic [5:0] addr6      = 6'(reg_addr);
  wire logic [7:0] wd         = 8'(reg_wdata);
  wire logic       locked     = (lock_reg == stepper_regs_pkg::LOCK_ON);
  wire logic       hit_oc     = (addr6 == stepper_regs_pkg::ADDR_OC_DIAG);
  wire logic       hit_therm  = (addr6 == stepper_regs_pkg::ADDR_THERMAL);
  wire logic       hit_c1     = (addr6 == stepper_regs_pkg::ADDR_TORQUE_SLEW);
  wire logic       hit_c2     = (addr6 == stepper_regs_pkg::ADDR_OUT_DECAY);
  wire logic       hit_c3     = (addr6 == stepper_regs_pkg::ADDR_CTRL_3);
  wire logic       hit_c4     = (addr6 == stepper_regs_pkg::ADDR_CTRL_4);
  wire logic       hit_c5     = (addr6 == stepper_regs_pkg::ADDR_CTRL_5);
  wire logic       hit_c6     = (addr6 == stepper_regs_pkg::ADDR_CTRL_6);
  wire logic       hit_c7     = (addr6 == stepper_regs_pkg::ADDR_CTRL_7);
  // (RULE_17) locked writes dropped
  wire logic       wr_ok      = reg_wr_en & ~locked;
  wire logic [2:0] wr_lock    = wd[stepper_regs_pkg::LOCK_LSB +: 3];
  // (RULE_18) clear honoured even when locked
  wire logic       clr_req    = reg_wr_en & hit_c4 & wd[stepper_regs_pkg::CLR_BIT];

  // (RULE_17) lock engages or releases on exact codes only
  wire logic       lock_set   = reg_wr_en & hit_c4 & ~locked
                                & (wr_lock == stepper_regs_pkg::LOCK_ON);
  wire logic       lock_rel   = reg_wr_en & hit_c4 & locked
                                & (wr_lock == stepper_regs_pkg::LOCK_OFF);
  wire logic [2:0] lock_next  = lock_set ? stepper_regs_pkg::LOCK_ON :
                                lock_rel ? stepper_regs_pkg::LOCK_OFF : lock_reg;

  // (RULE_02) second bridge flags in the upper nibble
  // (RULE_03) first bridge flags in the lower nibble
  // (RULE_19) detector inputs feed the flags
  wire logic [7:0] oc_det     = {oc_b_half2_low, oc_b_half2_high,
                                 oc_b_half1_low, oc_b_half1_high,
                                 oc_a_half2_low, oc_a_half2_high,
                                 oc_a_half1_low, oc_a_half1_high};
  // (RULE_04) thermal bits, (RULE_06) reserved bit zero
  // (RULE_05) learning done flag
  // (RULE_07) open-load flags
  wire logic [7:0] therm_det  = {under_temp_warning, over_temp_warning,
                                 over_temp_shutdown, stall_learning_done,
                                 stall_detect, 1'h0,
                                 open_load_second_bridge, open_load_first_bridge};
  wire logic [7:0] oc_next    = latch_flags(oc_diag_reg, oc_det, clr_req);
  wire logic [7:0] therm_next = latch_flags(thermal_reg, therm_det, clr_req);

  // (RULE_12) effective disable is bit or pin
  wire logic       dis_next   = out_decay_reg[stepper_regs_pkg::OUT_DIS_BIT]
                                | driver_off_pin;

  // readback select; unmapped addresses read zero
  wire logic [7:0] c4_read    = {1'h0, lock_reg, ctrl_4_low_reg};
  wire logic [7:0] rd_sel     = hit_oc    ? oc_diag_reg :
                                hit_therm ? thermal_reg :
                                hit_c1    ? torque_slew_reg :
                                hit_c2    ? out_decay_reg :
                                hit_c3    ? ctrl_3_reg :
                                hit_c4    ? c4_read :
                                hit_c5    ? ctrl_5_reg :
                                hit_c6    ? ctrl_6_reg :
                                hit_c7    ? ctrl_7_reg : 8'h00;

  // (RULE_01) status flags, never loaded from the write data
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      oc_diag_reg <= 8'h00;
      thermal_reg <= 8'h00;
    end else begin
      oc_diag_reg <= oc_next;
      thermal_reg <= therm_next;
    end
  end

  // (RULE_08) writable control registers 0x03..0x09 except 0x06
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      torque_slew_reg <= stepper_regs_pkg::TORQUE_SLEW_RST;
      out_decay_reg   <= stepper_regs_pkg::OUT_DECAY_RST
                         | {OUT_DIS_RESET, 7'h00};
      ctrl_3_reg      <= stepper_regs_pkg::CTRL_3_RST;
      ctrl_5_reg      <= stepper_regs_pkg::CTRL_5_RST;
      ctrl_6_reg      <= stepper_regs_pkg::CTRL_6_RST;
      ctrl_7_reg      <= stepper_regs_pkg::CTRL_7_RST;
    end else begin
      if (wr_ok && hit_c1) torque_slew_reg <= wd;
      if (wr_ok && hit_c2) out_decay_reg <= wd;
      if (wr_ok && hit_c3) ctrl_3_reg <= wd;
      if (wr_ok && hit_c5) ctrl_5_reg <= wd;
      if (wr_ok && hit_c6) ctrl_6_reg <= wd;
      if (wr_ok && hit_c7) ctrl_7_reg <= wd;
    end
  end

  // (RULE_17) lock field and low bits of 0x06
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_4_low_reg <= stepper_regs_pkg::CTRL_4_LOW_RST;
      lock_reg       <= stepper_regs_pkg::LOCK_RST;
      locked_reg     <= 1'h0;
    end else begin
      if (wr_ok && hit_c4) ctrl_4_low_reg <= wd[3:0];
      lock_reg <= lock_next;
      locked_reg <= (lock_next == stepper_regs_pkg::LOCK_ON);
    end
  end

  // derived outputs and clear pulse
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      out_dis_reg     <= 1'h1;
      off_cyc_reg     <= stepper_regs_pkg::OFF_CYC_1;
      fault_clear_reg <= 1'h0;
    end else begin
      out_dis_reg     <= dis_next;
      // (RULE_14) off time count from code
      off_cyc_reg     <= off_cycles(out_decay_reg[stepper_regs_pkg::OFF_LSB +: 2]);
      // (RULE_18) one-cycle clear pulse
      fault_clear_reg <= clr_req;
    end
  end

  // registered read answer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_reg    <= 8'h00;
      rd_valid_reg <= 1'h0;
    end else begin
      rd_valid_reg <= reg_rd_en;
      if (reg_rd_en) rdata_reg <= rd_sel;
    end
  end

  assign reg_rdata               = DATA_W'(rdata_reg);
  assign reg_rd_valid            = rd_valid_reg;
  // (RULE_09) torque scale field
  assign torque_scale            = torque_slew_reg[stepper_regs_pkg::TORQUE_LSB +: 4];
  // (RULE_10) slew rate field
  assign slew_rate               = torque_slew_reg[stepper_regs_pkg::SLEW_LSB +: 2];
  // (RULE_11) outputs hi-z while set
  assign output_disable          = out_dis_reg;
  assign pwm_off_time            = out_decay_reg[stepper_regs_pkg::OFF_LSB +: 2];
  assign pwm_off_cycles          = off_cyc_reg;
  // (RULE_15) decay code passed to the chopper
  // (RULE_16) adaptive codes, reset 111b
  assign decay_mode              = out_decay_reg[stepper_regs_pkg::DECAY_LSB +: 3];
  assign open_load_detect_enable = ctrl_4_low_reg[3];
  assign fault_clear             = fault_clear_reg;
  assign regs_locked             = locked_reg;

  // checks
  property p_oc_ro;
    @(posedge clk) disable iff (rst)
      (reg_wr_en && hit_oc && oc_det == 8'h00 && !clr_req)
      |=> (oc_diag_reg == $past(oc_diag_reg));
  endproperty
  a_oc_ro: assert property (p_oc_ro) else $error("overcurrent diag changed on write"); // RULE_01

  property p_oc_second;
    @(posedge clk) disable iff (rst)
      oc_b_half2_low |=> oc_diag_reg[7] ##1 (oc_diag_reg[7] || $past(clr_req));
  endproperty
  a_oc_second: assert property (p_oc_second) else $error("bit 7 flag not latched"); // RULE_02

  property p_oc_first;
    @(posedge clk) disable iff (rst)
      oc_a_half1_high |=> oc_diag_reg[0];
  endproperty
  a_oc_first: assert property (p_oc_first) else $error("bit 0 flag not latched"); // RULE_03

  property p_thermal;
    @(posedge clk) disable iff (rst)
      over_temp_shutdown |=> thermal_reg[5];
  endproperty
  a_thermal: assert property (p_thermal) else $error("shutdown flag not set"); // RULE_04

  property p_rsvd;
    @(posedge clk) disable iff (rst)
      reg_rd_en && hit_therm |=> !reg_rdata[stepper_regs_pkg::RSVD_DIAG];
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved diag bit read one"); // RULE_06

  property p_clear;
    @(posedge clk) disable iff (rst)
      (clr_req && oc_det == 8'h00 && therm_det == 8'h00)
      |=> (oc_diag_reg == 8'h00) && (thermal_reg == 8'h00) && fault_clear
      ##1 (fault_clear == $past(clr_req));
  endproperty
  a_clear: assert property (p_clear) else $error("fault clear did not act"); // RULE_18

  property p_lock;
    @(posedge clk) disable iff (rst)
      (regs_locked && reg_wr_en && hit_c1) |=> $stable(torque_slew_reg);
  endproperty
  a_lock: assert property (p_lock) else $error("write passed while locked"); // RULE_17

  property p_dis;
    @(posedge clk) disable iff (rst)
      driver_off_pin |=> output_disable;
  endproperty
  a_dis: assert property (p_dis) else $error("driver-off pin did not disable"); // RULE_12

  property p_off;
    @(posedge clk) disable iff (rst)
      (pwm_off_time == 2'h3) [*2] |-> (pwm_off_cycles == stepper_regs_pkg::OFF_CYC_3);
  endproperty
  a_off: assert property (p_off) else $error("off time count mismatch"); // RULE_14

endmodule // stepper_diag_and_ctrl_regs

// file: tb/host_port_model.sv
// host side of the register port: strobed writes and reads
// assumes the block samples the strobes on the rising clock edge
`timescale 1ns/1ps

module host_port_model (
  // clock
  input  wire logic       clk,
  // register port
  output logic            reg_wr_en,
  output logic            reg_rd_en,
  output logic [5:0]      reg_addr,
  output logic [7:0]      reg_wdata
);

  initial begin
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_addr  = 6'h00;
    reg_wdata = 8'h00;
  end

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr_en <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr_en <= 1'b0;
    // released lines must not look valid
    reg_addr  <= ~a;
    reg_wdata <= ~d;
  endtask

  task automatic rd(input logic [5:0] a);
    @(posedge clk);
    reg_rd_en <= 1'b1;
    reg_addr  <= a;
    @(posedge clk);
    reg_rd_en <= 1'b0;
    reg_addr  <= ~a;
  endtask

endmodule // host_port_model

// file: tb/testbench.sv
// self-checking bench for the stepper diagnostic and control registers
// assumes host_port_model drives the register port
`timescale 1ns/1ps

module testbench;
  logic        clk, rst, reg_wr_en, reg_rd_en, reg_rd_valid, driver_off_pin;
  logic [5:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, oc_v;
  logic [6:0]  th_v;
  logic [3:0]  torque_scale;
  logic [1:0]  slew_rate, pwm_off_time;
  logic [11:0] pwm_off_cycles;
  logic [2:0]  decay_mode;
  logic        output_disable, open_load_detect_enable, fault_clear, regs_locked;
  logic [7:0]  exp_q[$];
  logic [31:0] lfsr;
  int          error_cnt = 0;
  int          check_count = 0;
  logic [7:0]  rst_img[11] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h0F, 8'h00,
                               8'h30, 8'h08, 8'h00, 8'h00, 8'h00};
  int          off_us[4] = '{7, 16, 24, 32};

  stepper_diag_and_ctrl_regs #(.OUT_DIS_RESET(1'h0)) i_stepper_diag_and_ctrl_regs (
    .clk(clk), .rst(rst), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rd_valid(reg_rd_valid), .oc_b_half2_low(oc_v[7]), .oc_b_half2_high(oc_v[6]),
    .oc_b_half1_low(oc_v[5]), .oc_b_half1_high(oc_v[4]), .oc_a_half2_low(oc_v[3]),
    .oc_a_half2_high(oc_v[2]), .oc_a_half1_low(oc_v[1]), .oc_a_half1_high(oc_v[0]),
    .under_temp_warning(th_v[6]), .over_temp_warning(th_v[5]),
    .over_temp_shutdown(th_v[4]), .stall_learning_done(th_v[3]), .stall_detect(th_v[2]),
    .open_load_second_bridge(th_v[1]), .open_load_first_bridge(th_v[0]),
    .driver_off_pin(driver_off_pin), .torque_scale(torque_scale), .slew_rate(slew_rate),
    .output_disable(output_disable), .pwm_off_time(pwm_off_time),
    .pwm_off_cycles(pwm_off_cycles), .decay_mode(decay_mode),
    .open_load_detect_enable(open_load_detect_enable), .fault_clear(fault_clear),
    .regs_locked(regs_locked));

  host_port_model u_host_port_model (.clk(clk), .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  function automatic logic [31:0] lfsr_step(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  task automatic report_and_stop;
    if (error_cnt == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic chk_rd(input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] reg_rdata exp %h got %h", e, g);
    end
  endtask

  task automatic chk_out(input string n, input logic [11:0] e, input logic [11:0] g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask

  task automatic rd_exp(input logic [5:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    u_host_port_model.rd(a);
  endtask

  // let registered and one-cycle-late outputs land
  task automatic settle;
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic pulse_det(input logic [7:0] o, input logic [6:0] t);
    @(posedge clk);
    oc_v <= o;
    th_v <= t;
    @(posedge clk);
    oc_v <= 8'h00;
    th_v <= 7'h00;
  endtask

  // read answers checked in issue order
  always @(negedge clk) begin
    if (reg_rd_valid === 1'b1) begin
      if (exp_q.size() > 0) chk_rd(exp_q.pop_front(), reg_rdata);
      else chk_out("unexpected read", 12'h000, 12'h001);
    end
  end

  initial begin
    #100000;
    error_cnt++;
    report_and_stop();
  end

  initial begin
    logic [7:0] o;
    logic [6:0] t;
    rst = 1'b1;
    driver_off_pin = 1'b0;
    oc_v = 8'h00;
    th_v = 7'h00;
    lfsr = 32'h000123CB;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    for (int a = 0; a < 11; a++) rd_exp(6'(a), rst_img[a]);
    #1;
    chk_out("pwm_off_time", 12'h001, pwm_off_time);
    chk_out("decay_mode", 12'h007, decay_mode);
    chk_out("output_disable", 12'h000, output_disable);
    for (int a = 0; a < 11; a += 10) u_host_port_model.wr(6'(a), 8'hFF);
    u_host_port_model.wr(6'h01, 8'hFF);
    u_host_port_model.wr(6'h02, 8'hFF);
    for (int a = 0; a < 3; a++) rd_exp(6'(a), 8'h00);
    rd_exp(6'h0A, 8'h00);
    for (int c = 0; c < 16; c++) begin
      lfsr = lfsr_step(lfsr);
      u_host_port_model.wr(6'h03, {4'(c), 2'b00, lfsr[1:0]});
      settle();
      chk_out("torque_scale", 12'(c), torque_scale);
      chk_out("slew_rate", 12'(lfsr[1:0]), slew_rate);
      rd_exp(6'h03, {4'(c), 2'b00, lfsr[1:0]});
    end
    for (int c = 0; c < 32; c++) begin
      u_host_port_model.wr(6'h04, 8'(c));
      settle();
      chk_out("pwm_off_time", 12'(c / 8), pwm_off_time);
      chk_out("pwm_off_cycles", 12'(off_us[c / 8] * stepper_regs_pkg::CLK_MHZ),
              pwm_off_cycles);
      chk_out("decay_mode", 12'(c % 8), decay_mode);
      rd_exp(6'h04, 8'(c));
    end
    u_host_port_model.wr(6'h06, 8'h38);
    settle();
    chk_out("open_load_detect_enable", 12'h001, open_load_detect_enable);
    u_host_port_model.wr(6'h06, 8'h30);
    u_host_port_model.wr(6'h04, 8'h8F);
    settle();
    chk_out("open_load_detect_enable", 12'h000, open_load_detect_enable);
    chk_out("output_disable", 12'h001, output_disable);
    u_host_port_model.wr(6'h04, 8'h0F);
    driver_off_pin <= 1'b1;
    settle();
    chk_out("output_disable", 12'h001, output_disable);
    @(posedge clk);
    driver_off_pin <= 1'b0;
    settle();
    chk_out("output_disable", 12'h000, output_disable);
    for (int i = 0; i < 6; i++) begin
      lfsr = lfsr_step(lfsr);
      o = (i == 0) ? 8'hFF : lfsr[7:0];
      t = (i == 0) ? 7'h7F : lfsr[14:8];
      pulse_det(o, t);
      rd_exp(6'h01, o);
      rd_exp(6'h02, {t[6:2], 1'b0, t[1:0]});
      u_host_port_model.wr(6'h06, 8'hB0);
      #1;
      chk_out("fault_clear", 12'h001, fault_clear);
      @(posedge clk);
      #1;
      chk_out("fault_clear", 12'h000, fault_clear);
      rd_exp(6'h01, 8'h00);
      rd_exp(6'h02, 8'h00);
    end
    u_host_port_model.wr(6'h03, 8'h52);
    u_host_port_model.wr(6'h06, 8'h60);
    u_host_port_model.wr(6'h03, 8'hF3);
    settle();
    chk_out("regs_locked", 12'h001, regs_locked);
    chk_out("torque_scale", 12'h005, torque_scale);
    rd_exp(6'h06, 8'h60);
    pulse_det(8'h00, 7'h04);
    rd_exp(6'h02, 8'h08);
    u_host_port_model.wr(6'h06, 8'hE0);
    rd_exp(6'h02, 8'h00);
    u_host_port_model.wr(6'h06, 8'h30);
    u_host_port_model.wr(6'h03, 8'hF3);
    settle();
    chk_out("regs_locked", 12'h000, regs_locked);
    chk_out("torque_scale", 12'h00F, torque_scale);
    repeat (4) @(posedge clk);
    if (exp_q.size() != 0) error_cnt++;
    report_and_stop();
  end

endmodule // testbench
